// ---- verilog/cdb_exec.v ----
// execute stage for three instructions: complement, decrement-skip-zero,
// unconditional branch. expects the register file to present the
// addressed byte combinationally on file_rd_data for file_addr.
// ce low holds every output as it stands, write pulses included, so the
// register file must gate its own writes with the same enable.
// fetch_valid low turns the slot into a bubble; the counter still steps.
//
// Overview of operation
// RL1 - 00 1001 d fffffff: invert addressed register, set zero flag from result
// RL2 - complement result goes to accumulator when d=0, to register when d=1
// RL3 - 00 1011 d fffffff decodes decrement-skip; address spans 0 to 127
// RL4 - decrement by one; result to accumulator when d=0, else register
// RL5 - zero result discards fetched next word, runs no-op; no flags change
// RL6 - 10 1 kkkkkkkkkkk is the branch; target 0..2047; flags untouched
// RL7 - branch loads 11-bit literal into program counter bits 10..0
// RL8 - branch takes counter bits 12..11 from page latch bits 4..3
// RL9 - branch takes two cycles; complement takes one
// RL10 - branch or taken skip flushes prefetched word, refetches from new counter
`timescale 1ns/1ps
`include "cdb_defines.vh"

module cdb_exec (
   clk,
   rst_b,
   ce,
   fetch_word,
   fetch_valid,
   page_latch_register,
   file_rd_data,
   file_addr,
   file_wr_en,
   file_wr_data,
   acc_wr_en,
   acc_wr_data,
   zero_wr_en,
   zero_value,
   pc_ff,
   flush,
   complement_file_op,
   decrement_skip_zero_op,
   unconditional_branch_op,
   no_operation
);
   input wire clk;
   input wire rst_b;
   input wire ce;
   input wire [13:0] fetch_word;
   input wire fetch_valid;
   input wire [7:0] page_latch_register;
   input wire [7:0] file_rd_data;
   output wire [6:0] file_addr;
   output reg file_wr_en;
   output reg [7:0] file_wr_data;
   output reg acc_wr_en;
   output reg [7:0] acc_wr_data;
   output reg zero_wr_en;
   output reg zero_value;
   output reg [12:0] pc_ff;
   output wire flush;
   output wire complement_file_op;
   output wire decrement_skip_zero_op;
   output wire unconditional_branch_op;
   output wire no_operation;

   reg [13:0] instr_ff;
   reg nop_ff;
   wire [7:0] comp_res;
   wire [7:0] dec_res;
   wire dest;
   wire skip_taken;
   reg [12:0] nxt_pc;
   reg nxt_file_wr_en;
   reg [7:0] nxt_file_wr_data;
   reg nxt_acc_wr_en;
   reg [7:0] nxt_acc_wr_data;
   reg nxt_zero_wr_en;
   reg nxt_zero_value;
   reg [13:0] nxt_instr;
   reg nxt_nop;

   ////////////////////////////////////////////////////////////////////////
   // word and byte tests; kept as functions so decode and the flag
   // logic cannot drift apart
   function cdb_is_complement_file_op;
      input [13:0] word;
      begin
         // only the top six bits; d and f never alter the opcode
         cdb_is_complement_file_op = word[13:8] == `CDB_OP6_COMPLEMENT_FILE_OP;
      end
   endfunction

   function cdb_is_decsz;
      input [13:0] word;
      begin
         // same six-bit prefix width as complement
         cdb_is_decsz = word[13:8] == `CDB_OP6_DECSZ;
      end
   endfunction

   function cdb_is_branch;
      input [13:0] word;
      begin
         // three-bit prefix; the other eleven bits are the target
         cdb_is_branch = word[13:11] == `CDB_OP3_BRANCH;
      end
   endfunction

   function cdb_is_zero;
      input [7:0] value;
      begin
         cdb_is_zero = value == 8'h00;
      end
   endfunction

   function [12:0] cdb_branch_target;
      input [7:0] page;
      input [13:0] word;
      begin
         // page bits sit above the literal; the rest of the latch is ignored
         cdb_branch_target = {page[`CDB_PAGE_HI:`CDB_PAGE_LO], word[10:0]};
      end
   endfunction

   function [12:0] cdb_next_seq;
      input [12:0] pc;
      begin
         // wraps at the top of the 8K space, the counter has no carry out
         cdb_next_seq = pc + 13'h0001;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode of the word held in the execute slot
   // bubbles decode as nothing: nop_ff masks every opcode test
   assign complement_file_op = !nop_ff && cdb_is_complement_file_op(instr_ff); // see RL1
   assign decrement_skip_zero_op = !nop_ff && cdb_is_decsz(instr_ff); // see RL3
   assign unconditional_branch_op = !nop_ff && cdb_is_branch(instr_ff); // see RL6
   assign no_operation = nop_ff;
   assign file_addr = instr_ff[6:0]; // see RL3
   assign dest = instr_ff[`CDB_DEST_BIT];
   assign comp_res = ~file_rd_data; // see RL1
   assign dec_res = file_rd_data - 8'h01; // see RL4
   assign skip_taken = decrement_skip_zero_op && cdb_is_zero(dec_res); // see RL5
   // the slot after a branch or taken skip holds a discarded word
   assign flush = unconditional_branch_op | skip_taken; // see RL10

   always @* begin
      nxt_pc = cdb_next_seq(pc_ff);
      if (unconditional_branch_op) begin
         nxt_pc = cdb_branch_target(page_latch_register, instr_ff); // see RL7 see RL8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write-back, one cycle after execute
   // data regs keep their value between pulses; only the enables drop
   always @* begin
      nxt_file_wr_en = 1'b0;
      nxt_file_wr_data = file_wr_data;
      nxt_acc_wr_en = 1'b0;
      nxt_acc_wr_data = acc_wr_data;
      nxt_zero_wr_en = 1'b0; // see RL5 see RL6
      nxt_zero_value = zero_value;
      if (complement_file_op) begin
         nxt_file_wr_en = dest; // see RL2
         nxt_acc_wr_en = !dest; // see RL2
         nxt_file_wr_data = comp_res;
         nxt_acc_wr_data = comp_res;
         nxt_zero_wr_en = 1'b1; // see RL1
         nxt_zero_value = cdb_is_zero(comp_res);
      end else if (decrement_skip_zero_op) begin
         // decrement-skip leaves the zero flag alone; only complement loads it
         nxt_file_wr_en = dest; // see RL4
         nxt_acc_wr_en = !dest; // see RL4
         nxt_file_wr_data = dec_res;
         nxt_acc_wr_data = dec_res;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // reset clears the pulses so no stray write follows power-up
         file_wr_en <= 1'b0;
         file_wr_data <= 8'h00;
         acc_wr_en <= 1'b0;
         acc_wr_data <= 8'h00;
         zero_wr_en <= 1'b0;
         zero_value <= 1'b0;
      end else if (ce) begin
         file_wr_en <= nxt_file_wr_en;
         file_wr_data <= nxt_file_wr_data;
         acc_wr_en <= nxt_acc_wr_en;
         acc_wr_data <= nxt_acc_wr_data;
         zero_wr_en <= nxt_zero_wr_en;
         zero_value <= nxt_zero_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction slot and program counter; flush turns the next slot into
   // a no-op, giving two cycles for branch and taken skip
   // the counter steps even on a bubble so fetch stays one word ahead
   always @* begin
      nxt_instr = fetch_word; // see RL9
      nxt_nop = 1'b0;
      if (flush || !fetch_valid) begin
         nxt_instr = `CDB_NOP_WORD; // see RL5 see RL9 see RL10
         nxt_nop = 1'b1;
      end
   end

   // ce gates the whole update, freezing state and pulses alike
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_ff <= `CDB_NOP_WORD;
         nop_ff <= 1'b1;
         pc_ff <= `CDB_PC_RESET;
      end else if (ce) begin
         pc_ff <= nxt_pc; // see RL10
         instr_ff <= nxt_instr;
         nop_ff <= nxt_nop;
      end
   end
endmodule // cdb_exec

// ---- verilog/cdb_defines.vh ----
// constants for the complement / decrement-skip / branch execute block
// assumes 14-bit instruction words and 8-bit data
`ifndef CDB_DEFINES_VH
`define CDB_DEFINES_VH
`define CDB_OP6_COMPLEMENT_FILE_OP 6'h09
`define CDB_OP6_DECSZ 6'h0B
`define CDB_OP3_BRANCH 3'h5
`define CDB_NOP_WORD 14'h0000
`define CDB_PC_RESET 13'h0000
`define CDB_DEST_BIT 7
`define CDB_PAGE_HI 4
`define CDB_PAGE_LO 3
`endif

// ---- testbench/cdb_exec_monitor.sv ----
// port checks for cdb_exec; one clock, async low reset
`timescale 1ns/1ps
module cdb_exec_monitor (input wire clk, rst_b, ce, flush, no_operation, zero_wr_en,
   input wire zero_value, acc_wr_en, file_wr_en, complement_file_op, decrement_skip_zero_op,
   input wire unconditional_branch_op, input wire [7:0] file_rd_data, acc_wr_data,
   input wire [7:0] page_latch_register, input wire [12:0] pc_ff);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire cp = complement_file_op & ce;
   wire wr = acc_wr_en | file_wr_en | zero_wr_en;
   wire [1:0] pg = page_latch_register[4:3];
   a_cpl_value: assert property (cp |=>
      !acc_wr_en || acc_wr_data == ~$past(file_rd_data)) else $error("bad inverse");
   a_cpl_zero: assert property (cp |=>
      zero_wr_en && zero_value == ($past(file_rd_data) == 8'hFF)) else $error("bad zero");
   a_one_dest: assert property (cp |=> acc_wr_en ^ file_wr_en) else $error("dest");
   a_dec_flags: assert property (decrement_skip_zero_op && ce |=> !zero_wr_en)
      else $error("dec flag");
   a_skip_flush: assert property (decrement_skip_zero_op |->
      flush == (file_rd_data == 8'h01)) else $error("skip");
   a_jump_page: assert property (unconditional_branch_op && ce |=>
      pc_ff[12:11] == $past(pg)) else $error("page");
   a_jump_quiet: assert property (unconditional_branch_op && ce |->
      flush ##1 !wr) else $error("jump");
   a_flush_drop: assert property (flush && ce |=> no_operation ##1 !wr)
      else $error("flush");
   c_cpl: cover property (cp);
   c_skip: cover property (decrement_skip_zero_op && flush);
   c_jump: cover property (unconditional_branch_op);
endmodule // cdb_exec_monitor
bind cdb_exec cdb_exec_monitor mon_u (.*);

// ---- testbench/cdb_regfile_model.sv ----
// register file model; a write lands one cycle after its slot
`timescale 1ns/1ps
module cdb_regfile_model (input wire clk, input wire file_wr_en, input wire [6:0] file_addr,
   input wire [7:0] file_wr_data, output wire [7:0] file_rd_data);
   reg [7:0] mem_ff [0:127];
   reg [6:0] wa_ff;
   assign file_rd_data = mem_ff[file_addr];
   always @(posedge clk) begin
      wa_ff <= file_addr;
      if (file_wr_en) mem_ff[wa_ff] <= file_wr_data;
   end
endmodule // cdb_regfile_model

// ---- testbench/test_complement_decskip_branch_exec.sv ----
// bench for cdb_exec; the register file model answers reads
`timescale 1ns/1ps
module test_complement_decskip_branch_exec;
   reg clk = 0, rst_b = 0, ce = 1, fetch_valid = 1, fl;
   reg [13:0] fetch_word = 14'h0000;
   reg [7:0] page_latch_register = 8'h00;
   wire [7:0] file_rd_data, file_wr_data, acc_wr_data;
   wire [6:0] file_addr;
   wire [12:0] pc_ff;
   wire file_wr_en, acc_wr_en, zero_wr_en, zero_value, flush, no_operation;
   wire complement_file_op, decrement_skip_zero_op, unconditional_branch_op;
   integer n_errors = 0, samples_checked = 0;
   always #5 clk = ~clk;
   cdb_exec dut_u (.*);
   cdb_regfile_model rf_u (.*);
   task chk(input ok);
      samples_checked++;
      if (!ok) begin n_errors++; $display("FAIL %0t bad result", $time); end
   endtask
   // trailing word is a complement that a flush must drop
   task exec(input [13:0] w, input [7:0] v);
      rf_u.mem_ff[w[6:0]] = v;
      @(negedge clk) fetch_word = w;
      @(negedge clk) fetch_word = 14'h0900;
      fl = flush;
      @(negedge clk) fetch_word = 14'h0000;
   endtask
   task s_cpl;
      exec(14'h0905, 8'h13);
      chk(acc_wr_en === 1'b1 && acc_wr_data === 8'hEC && zero_value === 1'b0);
      exec(14'h09C0, 8'hFF);
      chk(file_wr_en === 1'b1 && file_wr_data === 8'h00 && zero_value === 1'b1);
   endtask
   task s_skip;
      exec(14'h0B10, 8'h05);
      chk(fl === 1'b0 && acc_wr_en === 1'b1 && acc_wr_data === 8'h04);
      exec(14'h0BFF, 8'h01);
      chk(fl === 1'b1 && file_wr_data === 8'h00 && zero_wr_en === 1'b0);
   endtask
   task s_jump(input [7:0] pl, input [13:0] w, input [12:0] pc);
      page_latch_register = pl;
      exec(w, 8'h00);
      chk(fl === 1'b1 && pc_ff === pc && zero_wr_en === 1'b0);
      @(negedge clk) chk(acc_wr_en === 1'b0);
   endtask
   // ce low freezes slot and counter; a bubble still steps the counter
   task s_hold;
      reg [12:0] pc0;
      reg nop0;
      begin
         @(negedge clk) ce = 0;
         fetch_word = 14'h0905;
         pc0 = pc_ff;
         nop0 = no_operation;
         @(negedge clk) chk(pc_ff === pc0 && no_operation === nop0);
         ce = 1;
         fetch_valid = 0;
         @(negedge clk) chk(no_operation === 1'b1 && pc_ff === pc0 + 13'h0001);
         fetch_valid = 1;
         @(negedge clk) chk(complement_file_op === 1'b1 && file_addr === 7'h05);
         fetch_word = 14'h0000;
         @(negedge clk) chk(acc_wr_en === 1'b1 && acc_wr_data === 8'hEC);
      end
   endtask
   task end_sim;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      rf_u.mem_ff[0] = 8'h00;
      repeat (10) @(negedge clk);
      rst_b = 1;
      s_cpl;
      s_skip;
      s_jump(8'h18, 14'h2FFF, 13'h1FFF);
      s_jump(8'hE7, 14'h2D55, 13'h0555);
      rf_u.mem_ff[5] = 8'h13;
      s_hold;
      end_sim;
   end
endmodule // test_complement_decskip_branch_exec
